// ### rtl/vff_filter_tagger.v
// VLAN frame filter and tagger with AXI4-Lite configuration
// What this block does
// (RULE1) Drop trunk/provider data frames missing from forwarding list
// (RULE2) Forwarding support switch, off after reset
// (RULE3) Forwarding list: twenty IDs, 1..4094, one add
// (RULE4) Remove only a stored ID within 1..4094
// (RULE5) Forwarding on with empty list drops data
// (RULE6) Access point drops relayed frames missing from relaying list
// (RULE7) Relaying list of twenty, relaying off by default
// (RULE8) Relaying on with empty list drops relayed frames
// (RULE9) Software also puts relaying IDs in forwarding list
// (RULE10) Subscriber provider VLAN ID 1..4094, default 1
// (RULE11) Matching provider tag stripped toward Ethernet
// (RULE12) Provider tag inserted on every Ethernet-side frame
// (RULE13) Access-link data priority 0..7 toward wireless, default 0
// (RULE14) Data to low queue, management to high
// (RULE15) Management priority written unless management VID 65535
// (RULE16) Provider Ethertype 8100..9000, 9100, 9200, default 8100
// (RULE17) Broadcast filter blocks group destination addresses
// (RULE18) Filter option: off, Ethernet, wireless or both
// (RULE19) DHCP, PPPoE, ARP overrides let broadcasts pass
// (RULE20) Duplicate or overflowing add leaves list unchanged
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "vff_consts.vh"

module vff_filter_tagger
#(
   parameter IS_SUBSCRIBER = 1,
   parameter LIST_DEPTH = `VFF_LIST_DEPTH
)
(
   input wire aclk,
   input wire aresetn,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire frm_valid,
   output wire frm_ready,
   input wire frm_from_wireless,
   input wire frm_to_wireless,
   input wire frm_is_mgmt,
   input wire [1:0] frm_tag_count,
   input wire [15:0] frm_outer_etype,
   input wire [11:0] frm_outer_vid,
   input wire [11:0] frm_inner_vid,
   input wire frm_dst_group,
   input wire [1:0] frm_proto,
   output reg dec_valid,
   input wire dec_ready,
   output reg dec_pass,
   output reg dec_strip_outer,
   output reg dec_insert,
   output reg [15:0] dec_tag_etype,
   output reg [11:0] dec_tag_vid,
   output reg dec_pcp_write,
   output reg [2:0] dec_pcp,
   output reg dec_queue_high
);
   localparam CW = 5;

   reg [9:0] ctrl_q;
   reg [11:0] spvid_q;
   reg [15:0] qinq_q;
   reg [2:0] dprio_q;
   reg [2:0] mprio_q;
   reg [15:0] mvid_q;
   reg cmd_ok_q;
   reg [4:0] awaddr_q;
   reg aw_got_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_got_q;

   wire [CW-1:0] fwd_count;
   wire [CW-1:0] rly_count;
   wire fwd_hit;
   wire rly_hit;
   wire fwd_cmd_ok;
   wire rly_cmd_ok;

   // Write channel: address and data accepted in either order
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_got_q || aw_take;
   wire w_have = w_got_q || w_take;
   wire wr_do = aw_have && w_have;
   wire [4:0] wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
   wire [3:0] wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
   wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                          {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready = !w_got_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire sel_ctrl = (wr_addr == {1'b0, `VFF_ADDR_CTRL});
   wire sel_spvid = (wr_addr == {1'b0, `VFF_ADDR_SPVID});
   wire sel_qinq = (wr_addr == {1'b0, `VFF_ADDR_QINQ});
   wire sel_prio = (wr_addr == {1'b0, `VFF_ADDR_PRIO});
   wire sel_mvid = (wr_addr == `VFF_ADDR_MVID);
   wire sel_list = (wr_addr == `VFF_ADDR_LIST);
   wire wr_mapped = sel_ctrl || sel_spvid || sel_qinq || sel_prio ||
                    sel_mvid || sel_list;

   // Merged values after byte enables
   wire [31:0] ctrl_m = ({22'h0, ctrl_q} & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] spvid_m = ({20'h0, spvid_q} & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] qinq_m = ({16'h0, qinq_q} & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] prio_old = {25'h0, mprio_q, 1'b0, dprio_q};
   wire [31:0] prio_m = (prio_old & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] mvid_m = ({16'h0, mvid_q} & ~wr_mask) | (wr_data & wr_mask);

   wire spvid_ok = (spvid_m[11:0] >= `VFF_VID_MIN) &&
                   (spvid_m[11:0] <= `VFF_VID_MAX); // RULE10
   wire qinq_ok = ((qinq_m[15:0] >= `VFF_QINQ_MIN) &&
                   (qinq_m[15:0] <= `VFF_QINQ_MAX)) ||
                  (qinq_m[15:0] == `VFF_QINQ_ALT1) ||
                  (qinq_m[15:0] == `VFF_QINQ_ALT2); // RULE16

   wire list_cmd = wr_do && sel_list && wr_strb[0] && wr_strb[1];
   wire list_rly = wr_data[`VFF_LIST_CMD_SEL];
   wire list_rem = wr_data[`VFF_LIST_CMD_REMOVE];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 5'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `VFF_RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            awaddr_q <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `VFF_RESP_OKAY : `VFF_RESP_SLVERR;
         end
         else
         begin
            if (aw_take)
               aw_got_q <= 1'b1;
            if (w_take)
               w_got_q <= 1'b1;
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; out-of-range provider VLAN ID and Ethertype values are ignored
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= `VFF_CTRL_RST; // RULE2 RULE7 RULE18 RULE19
         spvid_q <= `VFF_SPVID_RST; // RULE10
         qinq_q <= `VFF_QINQ_RST; // RULE16
         dprio_q <= `VFF_DPRIO_RST; // RULE13
         mprio_q <= (IS_SUBSCRIBER != 0) ? `VFF_MPRIO_SUB_RST :
                    `VFF_MPRIO_AP_RST; // RULE15
         mvid_q <= `VFF_MVID_RST;
         cmd_ok_q <= 1'b0;
      end
      else if (wr_do)
      begin
         if (sel_ctrl)
            ctrl_q <= ctrl_m[9:0]; // RULE2
         if (sel_spvid && spvid_ok)
            spvid_q <= spvid_m[11:0];
         if (sel_qinq && qinq_ok)
            qinq_q <= qinq_m[15:0];
         if (sel_prio)
         begin
            dprio_q <= prio_m[2:0];
            mprio_q <= prio_m[`VFF_PRIO_MGMT_LO+2:`VFF_PRIO_MGMT_LO];
         end
         if (sel_mvid)
            mvid_q <= mvid_m[15:0];
         if (list_cmd)
            cmd_ok_q <= list_rly ? rly_cmd_ok : fwd_cmd_ok;
      end
   end

   // Read channel
   reg [31:0] rd_word;
   reg rd_hit;
   always @*
   begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         {1'b0, `VFF_ADDR_CTRL}: rd_word = {22'h0, ctrl_q};
         {1'b0, `VFF_ADDR_SPVID}: rd_word = {20'h0, spvid_q};
         {1'b0, `VFF_ADDR_QINQ}: rd_word = {16'h0, qinq_q};
         {1'b0, `VFF_ADDR_PRIO}: rd_word = prio_old;
         `VFF_ADDR_MVID: rd_word = {16'h0, mvid_q};
         `VFF_ADDR_LIST: rd_word = {15'h0, cmd_ok_q, 3'h0, rly_count,
                                   3'h0, fwd_count};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `VFF_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `VFF_RESP_OKAY : `VFF_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Frame decision
   wire is_sub = (IS_SUBSCRIBER != 0);
   wire [1:0] link = ctrl_q[`VFF_CTRL_LINK_LO+1:`VFF_CTRL_LINK_LO];
   wire [1:0] bcf = ctrl_q[`VFF_CTRL_BCF_LO+1:`VFF_CTRL_BCF_LO];
   wire link_access = (link == `VFF_LINK_ACCESS);
   wire link_sp = (link == `VFF_LINK_PROVIDER);
   wire link_tr_sp = (link == `VFF_LINK_TRUNK) || link_sp;
   wire is_data = !frm_is_mgmt;
   wire sub_sp = is_sub && link_sp;

   // Subscriber on provider link checks the customer tag behind the SP tag
   wire cust_inner = sub_sp && frm_from_wireless;
   wire has_cust = cust_inner ? (frm_tag_count == 2'h2) :
                   (frm_tag_count != 2'h0);
   wire [11:0] fwd_vid = cust_inner ? frm_inner_vid : frm_outer_vid;
   wire fwd_on = link_tr_sp && ctrl_q[`VFF_CTRL_FWD_EN];
   wire fwd_drop = fwd_on && is_data &&
                   ((fwd_count == {CW{1'b0}}) || // RULE5
                    (has_cust && !fwd_hit)); // RULE1

   wire relayed = frm_from_wireless && frm_to_wireless;
   wire rly_on = !is_sub && link_tr_sp && ctrl_q[`VFF_CTRL_RELAY_EN];
   wire rly_drop = rly_on && is_data && relayed &&
                   ((rly_count == {CW{1'b0}}) || !rly_hit); // RULE6 RULE8

   wire sp_match = (frm_tag_count != 2'h0) && (frm_outer_etype == qinq_q) &&
                   (frm_outer_vid == spvid_q);
   wire sp_strip = sub_sp && frm_from_wireless; // RULE11
   wire sp_drop = sp_strip && !sp_match; // RULE11
   wire sp_insert = sub_sp && !frm_from_wireless; // RULE12

   wire bcf_port = frm_from_wireless ?
                   (bcf == `VFF_BCF_WL || bcf == `VFF_BCF_BOTH) :
                   (bcf == `VFF_BCF_ETH || bcf == `VFF_BCF_BOTH); // RULE18
   wire bc_ovr = (frm_proto == `VFF_PROTO_DHCP &&
                  ctrl_q[`VFF_CTRL_DHCP_OVR]) ||
                 (frm_proto == `VFF_PROTO_PPPOE &&
                  ctrl_q[`VFF_CTRL_PPPOE_OVR]) ||
                 (frm_proto == `VFF_PROTO_ARP &&
                  ctrl_q[`VFF_CTRL_ARP_OVR]); // RULE19
   wire bc_drop = is_sub && bcf_port && frm_dst_group && !bc_ovr; // RULE17

   wire mgmt_pcp = frm_is_mgmt && (mvid_q != `VFF_MVID_NONE); // RULE15
   wire data_pcp = is_sub && link_access && is_data &&
                   !frm_from_wireless; // RULE13

   assign frm_ready = !dec_valid || dec_ready;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dec_valid <= 1'b0;
         dec_pass <= 1'b0;
         dec_strip_outer <= 1'b0;
         dec_insert <= 1'b0;
         dec_tag_etype <= 16'h0000;
         dec_tag_vid <= 12'h000;
         dec_pcp_write <= 1'b0;
         dec_pcp <= 3'h0;
         dec_queue_high <= 1'b0;
      end
      else if (frm_valid && frm_ready)
      begin
         dec_valid <= 1'b1;
         dec_pass <= !(fwd_drop || rly_drop || sp_drop || bc_drop);
         dec_strip_outer <= sp_strip;
         dec_insert <= sp_insert;
         dec_tag_etype <= qinq_q;
         dec_tag_vid <= spvid_q;
         dec_pcp_write <= mgmt_pcp || data_pcp;
         dec_pcp <= mgmt_pcp ? mprio_q : dprio_q;
         dec_queue_high <= frm_is_mgmt; // RULE14
      end
      else if (dec_ready)
         dec_valid <= 1'b0;
   end

   // Two lists; the relaying list is only consulted on an access point
   vff_vid_list #(.DEPTH(LIST_DEPTH), .CW(CW)) u_fwd_list
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .cmd_valid(list_cmd && !list_rly), // RULE3
      .cmd_remove(list_rem),
      .cmd_vid(wr_data[11:0]),
      .cmd_ok(fwd_cmd_ok),
      .look_vid(fwd_vid),
      .look_hit(fwd_hit),
      .count(fwd_count)
   );

   vff_vid_list #(.DEPTH(LIST_DEPTH), .CW(CW)) u_rly_list
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .cmd_valid(list_cmd && list_rly), // RULE7
      .cmd_remove(list_rem),
      .cmd_vid(wr_data[11:0]),
      .cmd_ok(rly_cmd_ok),
      .look_vid(frm_outer_vid),
      .look_hit(rly_hit),
      .count(rly_count)
   );
endmodule // vff_filter_tagger

// ### pkg/vff_consts.vh
// Register map, field positions and reset values of the VLAN filter
`ifndef VFF_CONSTS_VH
`define VFF_CONSTS_VH

`define VFF_ADDR_CTRL 4'h0
`define VFF_ADDR_SPVID 4'h4
`define VFF_ADDR_QINQ 4'h8
`define VFF_ADDR_PRIO 4'hc
`define VFF_ADDR_MGMT_VID 4'h0
`define VFF_ADDR_MVID 5'h10
`define VFF_ADDR_LIST 5'h14

`define VFF_CTRL_FWD_EN 0
`define VFF_CTRL_RELAY_EN 1
`define VFF_CTRL_LINK_LO 2
`define VFF_CTRL_BCF_LO 4
`define VFF_CTRL_DHCP_OVR 6
`define VFF_CTRL_PPPOE_OVR 7
`define VFF_CTRL_ARP_OVR 8
`define VFF_CTRL_RST 10'h100

`define VFF_LINK_ACCESS 2'h0
`define VFF_LINK_TRUNK 2'h1
`define VFF_LINK_PROVIDER 2'h2

`define VFF_BCF_OFF 2'h0
`define VFF_BCF_ETH 2'h1
`define VFF_BCF_WL 2'h2
`define VFF_BCF_BOTH 2'h3

`define VFF_PROTO_DHCP 2'h1
`define VFF_PROTO_PPPOE 2'h2
`define VFF_PROTO_ARP 2'h3

`define VFF_SPVID_RST 12'h001
`define VFF_VID_MIN 12'h001
`define VFF_VID_MAX 12'hffe
`define VFF_QINQ_RST 16'h8100
`define VFF_QINQ_MIN 16'h8100
`define VFF_QINQ_MAX 16'h9000
`define VFF_QINQ_ALT1 16'h9100
`define VFF_QINQ_ALT2 16'h9200
`define VFF_MVID_RST 16'hffff
`define VFF_MVID_NONE 16'hffff
`define VFF_DPRIO_RST 3'h0
`define VFF_MPRIO_SUB_RST 3'h4
`define VFF_MPRIO_AP_RST 3'h0
`define VFF_PRIO_MGMT_LO 4

`define VFF_LIST_CMD_SEL 12
`define VFF_LIST_CMD_REMOVE 13
`define VFF_LIST_DEPTH 20

`define VFF_RESP_OKAY 2'h0
`define VFF_RESP_SLVERR 2'h2

`endif

// ### rtl/vff_vid_list.v
// Small content-addressed list of VLAN IDs with add, remove and lookup
`timescale 1ns/1ps
`include "vff_consts.vh"

module vff_vid_list
#(
   parameter DEPTH = `VFF_LIST_DEPTH,
   parameter CW = 5
)
(
   input wire aclk,
   input wire aresetn,
   input wire cmd_valid,
   input wire cmd_remove,
   input wire [11:0] cmd_vid,
   output reg cmd_ok,
   input wire [11:0] look_vid,
   output reg look_hit,
   output reg [CW-1:0] count
);
   reg [11:0] vid_q [0:DEPTH-1];
   reg [DEPTH-1:0] used_q;
   reg [DEPTH-1:0] cmd_match;
   reg [DEPTH-1:0] free_first;
   reg seen_free;
   reg vid_ok;
   integer i;
   integer j;

   always @*
   begin
      look_hit = 1'b0;
      count = {CW{1'b0}};
      seen_free = 1'b0;
      free_first = {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
      begin
         cmd_match[i] = used_q[i] && (vid_q[i] == cmd_vid);
         if (used_q[i] && (vid_q[i] == look_vid))
            look_hit = 1'b1;
         if (used_q[i])
            count = count + {{(CW-1){1'b0}}, 1'b1};
         else if (!seen_free)
         begin
            free_first[i] = 1'b1;
            seen_free = 1'b1;
         end
      end
      vid_ok = (cmd_vid >= `VFF_VID_MIN) && (cmd_vid <= `VFF_VID_MAX);
      // Add refuses duplicates and a full list
      if (cmd_remove)
         cmd_ok = vid_ok && (|cmd_match); // RULE4
      else
         cmd_ok = vid_ok && !(|cmd_match) && seen_free; // RULE20
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         used_q <= {DEPTH{1'b0}};
      else if (cmd_valid && cmd_ok)
      begin
         if (cmd_remove)
            used_q <= used_q & ~cmd_match;
         else
            used_q <= used_q | free_first;
      end
   end

   always @(posedge aclk)
   begin
      for (j = 0; j < DEPTH; j = j + 1)
         if (cmd_valid && cmd_ok && !cmd_remove && free_first[j])
            vid_q[j] <= cmd_vid;
   end
endmodule // vff_vid_list

// ### tb/vff_chk_sva.sv
// Handshake and decision checks bound to the VLAN filter top
`timescale 1ns/1ps
module vff_chk
(
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire frm_valid,
   input wire frm_ready,
   input wire frm_is_mgmt,
   input wire frm_from_wireless,
   input wire dec_valid,
   input wire dec_ready,
   input wire dec_pass,
   input wire dec_strip_outer,
   input wire dec_insert,
   input wire [2:0] dec_pcp,
   input wire dec_queue_high
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_ready_follows_dec:
   assert property (frm_ready == (!dec_valid || dec_ready))
      else $error("frame ready wrong");
   a_dec_next_cycle:
   assert property (frm_valid && frm_ready |=> dec_valid)
      else $error("decision late");
   a_dec_held_stable:
   assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_pass)
      && $stable(dec_pcp) && $stable(dec_queue_high))
      else $error("decision not held");
   a_queue_by_kind:
   assert property (frm_valid && frm_ready |=>
      dec_queue_high == $past(frm_is_mgmt))
      else $error("wrong queue");
   a_tag_one_way:
   assert property (frm_valid && frm_ready |=>
      ($past(frm_from_wireless) ? !dec_insert : !dec_strip_outer))
      else $error("provider tag handled on wrong side");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_bresp_held:
   assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_bvalid_blocks_write:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_held:
   assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // vff_chk

bind vff_filter_tagger vff_chk i_chk (.*);

// ### tb/vff_dec_sink.sv
// Egress side taking decisions, with optional random stalls
`timescale 1ns/1ps
module vff_dec_sink
(
   input wire aclk,
   input wire aresetn,
   input wire stall_en,
   output reg dec_ready
);
   integer seed = 32'h05e0;
   initial dec_ready = 1'b1;
   always @(posedge aclk)
      if (!aresetn)
         dec_ready <= 1'b1;
      else
         dec_ready <= !stall_en || ($random(seed) % 3 != 0);
endmodule // vff_dec_sink

// ### tb/tb.sv
// Self-checking bench of the VLAN filter and tagger
`timescale 1ns/1ps
`include "vff_consts.vh"
module tb;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   wire [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stall_en = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, frm_ready, dec_valid, dec_ready, dec_pass;
   wire dec_strip_outer, dec_insert, dec_pcp_write, dec_queue_high;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] dec_tag_etype;
   wire [11:0] dec_tag_vid;
   wire [2:0] dec_pcp;
   wire ap_pass;
   reg frm_valid = 1'b0, frm_from_wireless = 1'b0, frm_to_wireless = 1'b0;
   reg frm_is_mgmt = 1'b0, frm_dst_group = 1'b0, rly = 1'b0;
   reg [1:0] frm_tag_count = 2'h0, frm_proto = 2'h0, r;
   reg [15:0] frm_outer_etype = 16'h0;
   reg [11:0] frm_outer_vid = 12'h0, frm_inner_vid = 12'h0, v, inner = 12'h0;
   reg [31:0] d;
   reg [7:0] res;
   integer i, seed = 32'h05e0, error_cnt = 0, num_checks = 0, cycles = 0;
   localparam [159:0] RV = {32'hffff, 32'h40, 32'h8100, 32'h1, 32'h100};

   vff_filter_tagger i_dut (.*);
   vff_dec_sink i_sink (.aclk(aclk), .aresetn(aresetn),
      .stall_en(stall_en), .dec_ready(dec_ready));
   // Access point twin in lockstep; only its pass decision is checked
   vff_filter_tagger #(.IS_SUBSCRIBER(0)) i_dut_ap (.*, .s_axi_awready(),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .frm_ready(),
      .dec_valid(), .dec_pass(ap_pass), .dec_strip_outer(), .dec_insert(),
      .dec_tag_etype(), .dec_tag_vid(), .dec_pcp_write(), .dec_pcp(),
      .dec_queue_high());

   initial forever #25 aclk = ~aclk;

   function [31:0] ctrl(input fwd, input [1:0] lk, input [1:0] bf,
      input [2:0] ov);
      ctrl = {23'h0, ov, bf, lk, 1'b0, fwd};
   endfunction
   // Stored list: 380..3800 in steps of 190, plus 4094
   function exp_fwd(input [11:0] x);
      exp_fwd = x == 12'd4094 || (x % 190 == 0 && x >= 380 && x <= 3800);
   endfunction
   function exp_bc(input [2:0] o, input [1:0] p);
      exp_bc = p != 2'h0 && o[p - 2'h1];
   endfunction

   task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task axi_wr(input [4:0] a, input [31:0] w, output [1:0] rs);
   begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   end
   endtask

   task axi_rd(input [4:0] a, output [31:0] rd, output [1:0] rs);
   begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   end
   endtask

   task list_cmd(input [31:0] w, input ok, input [4:0] cnt);
   begin
      axi_wr(`VFF_ADDR_LIST, w, r);
      axi_rd(`VFF_ADDR_LIST, d, r);
      chk(d[16], ok);
      chk(d[4:0], cnt);
   end
   endtask

   // Result bits: qh, pcp_write, pcp[2:0], insert, strip, pass
   task frame(input wl, input mg, input [1:0] tc, input [15:0] et,
      input [11:0] vid, input grp, input [1:0] pr);
   begin
      @(posedge aclk);
      frm_from_wireless <= wl;
      frm_to_wireless <= !wl || rly;
      frm_is_mgmt <= mg;
      frm_tag_count <= tc;
      frm_outer_etype <= et;
      frm_outer_vid <= vid;
      frm_inner_vid <= (tc == 2'h2) ? inner : vid;
      frm_dst_group <= grp;
      frm_proto <= pr;
      frm_valid <= 1'b1;
      do @(posedge aclk); while (!frm_ready);
      frm_valid <= 1'b0;
      do @(posedge aclk); while (!(dec_valid && dec_ready));
      res = {dec_queue_high, dec_pcp_write, dec_pcp, dec_insert,
         dec_strip_outer, dec_pass};
   end
   endtask

   task report_and_stop;
   begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   always @(posedge aclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 5; i = i + 1)
      begin
         axi_rd(i * 4, d, r);
         chk(d, RV[i * 32 +: 32]);
      end
      axi_rd(5'h18, d, r);
      chk(r, `VFF_RESP_SLVERR);
      axi_wr(5'h18, 32'h1, r);
      chk(r, `VFF_RESP_SLVERR);
      axi_wr(`VFF_ADDR_CTRL, ctrl(1, 1, 0, 3'h4), r);
      frame(0, 0, 1, 16'h8100, 12'd10, 0, 0);
      chk(res, 8'h00);
      frame(0, 1, 1, 16'h8100, 12'd10, 0, 0);
      chk({res[7], res[0]}, 2'b11);
      list_cmd(32'h0, 0, 0);
      for (i = 1; i <= 21; i = i + 1)
         list_cmd(i * 190, i <= 20, (i <= 20) ? i : 20);
      list_cmd(32'h2fff, 0, 20);
      list_cmd(32'h2000 | 190, 1, 19);
      list_cmd(32'd380, 0, 19);
      list_cmd(32'd4094, 1, 20);
      stall_en <= 1'b1;
      for (i = 0; i < 40; i = i + 1)
      begin
         v = (i % 2) ? ({$random(seed)} % 20 + 1) * 190
            : {$random(seed)} % 4094 + 1;
         frame(i % 3 == 0, 0, 1, 16'h8100, v, 0, 0);
         chk(res[0], exp_fwd(v));
      end
      stall_en <= 1'b0;
      axi_wr(`VFF_ADDR_CTRL, ctrl(0, 1, 0, 3'h4), r);
      frame(0, 0, 1, 16'h8100, 12'd7, 0, 0);
      chk(res[0], 1);
      axi_wr(`VFF_ADDR_CTRL, ctrl(0, 2, 0, 3'h4), r);
      axi_wr(`VFF_ADDR_SPVID, 32'h123, r);
      axi_wr(`VFF_ADDR_SPVID, 32'hfff, r);
      axi_rd(`VFF_ADDR_SPVID, d, r);
      chk(d, 32'h123);
      axi_wr(`VFF_ADDR_QINQ, 32'h9100, r);
      axi_wr(`VFF_ADDR_QINQ, 32'h9050, r);
      axi_rd(`VFF_ADDR_QINQ, d, r);
      chk(d, 32'h9100);
      frame(0, 0, 0, 16'h0, 12'h0, 0, 0);
      chk({res[2], res[0], dec_tag_etype, dec_tag_vid},
         {2'b11, 16'h9100, 12'h123});
      frame(1, 0, 1, 16'h9100, 12'h123, 0, 0);
      chk(res[1:0], 2'b11);
      frame(1, 0, 1, 16'h9100, 12'h124, 0, 0);
      chk(res[0], 0);
      axi_wr(`VFF_ADDR_CTRL, ctrl(1, 2, 0, 3'h4), r);
      inner = 12'd380;
      frame(1, 0, 2, 16'h9100, 12'h123, 0, 0);
      chk(res[1:0], 2'b11);
      inner = 12'd190;
      frame(1, 0, 2, 16'h9100, 12'h123, 0, 0);
      chk(res[0], 0);
      for (i = 0; i < 4; i = i + 1)
      begin
         axi_wr(`VFF_ADDR_CTRL, ctrl(0, 0, i, 3'h4), r);
         frame(0, 0, 0, 16'h0, 12'h0, 1, 0);
         chk(res[0], !i[0]);
         frame(1, 0, 0, 16'h0, 12'h0, 1, 0);
         chk(res[0], !i[1]);
      end
      for (i = 0; i < 32; i = i + 1)
      begin
         axi_wr(`VFF_ADDR_CTRL, ctrl(0, 0, 3, i[4:2]), r);
         frame(0, 0, 0, 16'h0, 12'h0, 1, i[1:0]);
         chk(res[0], exp_bc(i[4:2], i[1:0]));
      end
      axi_wr(`VFF_ADDR_CTRL, ctrl(0, 0, 0, 3'h4), r);
      axi_wr(`VFF_ADDR_PRIO, 32'h65, r);
      frame(0, 0, 0, 16'h0, 12'h0, 0, 0);
      chk(res[6:3], 4'hd);
      frame(0, 1, 0, 16'h0, 12'h0, 0, 0);
      chk(res[6], 0);
      axi_wr(`VFF_ADDR_MVID, 32'h00a, r);
      frame(0, 1, 0, 16'h0, 12'h0, 0, 0);
      chk(res[7:3], 5'b11110);
      // Frames sent back to the wireless side, seen by the access point
      rly = 1'b1;
      axi_wr(`VFF_ADDR_CTRL, ctrl(0, 1, 0, 3'h4) | 32'h2, r);
      frame(1, 0, 1, 16'h8100, 12'd380, 0, 0);
      chk(ap_pass, 0);
      list_cmd(32'h1000 | 380, 1, 20);
      chk(d[12:8], 1);
      axi_wr(`VFF_ADDR_CTRL, ctrl(1, 1, 0, 3'h4) | 32'h2, r);
      frame(1, 0, 1, 16'h8100, 12'd380, 0, 0);
      chk(ap_pass, 1);
      frame(1, 0, 1, 16'h8100, 12'd570, 0, 0);
      chk(ap_pass, 0);
      frame(0, 0, 1, 16'h8100, 12'd570, 0, 0);
      chk(ap_pass, 1);
      report_and_stop;
   end
endmodule // tb
